// file: logic/tmcm_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tmcm_defs.vh"

module tmcm_top (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst,
  // avalon-mm slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // test and reset pins
  input  wire        i_test_select_a_n,
  input  wire        i_test_select_b_n,
  input  wire        i_reset_pin_n,
  input  wire [3:0]  i_mode_sel,
  // oscillator clocks sampled as data
  input  wire        i_sys_rc_clk,
  input  wire        i_adc_rc_osc0,
  input  wire        i_adc_rc_osc1,
  // monitor pin
  input  wire        i_monitor_pin,
  output reg         o_monitor_pin,
  output reg         o_monitor_pin_oe_n,
  // oscillator control and inputs
  output reg         o_osc0_run,
  output reg  [1:0]  o_osc0_cfg,
  output reg         o_osc1_run,
  output reg  [1:0]  o_osc1_cfg,
  output reg         o_osc0_input,
  output reg         o_osc1_input,
  // device state
  output reg         o_test_mode,
  output reg         o_normal_run
);

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  wire [10:0] pins_s;
  tmcm_sync #(
    .WIDTH (11)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_monitor_pin, i_adc_rc_osc1, i_adc_rc_osc0, i_sys_rc_clk,
                  i_mode_sel, i_reset_pin_n, i_test_select_b_n, i_test_select_a_n}),
    .o_sync     (pins_s)
  );

  wire       tsa_s   = pins_s[0];
  wire       tsb_s   = pins_s[1];
  wire       rstp_s  = pins_s[2];
  wire [3:0] sel_s   = pins_s[6:3];
  wire       sysck_s = pins_s[7];
  wire       osc0_s  = pins_s[8];
  wire       osc1_s  = pins_s[9];
  wire       mon_s   = pins_s[10];

  // ----------------------------------------
  // test mode entry and exit
  // ----------------------------------------
  reg rstp_q;
  reg test_q;
  reg hold_q;
  reg [1:0] ctrl_q;

  // reset pin starts low so a pin already high at release counts as a release edge
  wire release_edge = rstp_s & ~rstp_q;

  // a release edge is checked first: it both ends a hold and may re-enter test
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rstp_q <= 1'b0;
      test_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      rstp_q <= rstp_s;
      if (release_edge) begin
        test_q <= tsa_s & ~tsb_s;
        hold_q <= 1'b0;
      end else if (test_q && tsa_s && tsb_s) begin
        test_q <= 1'b0;
        hold_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // monitor source selection
  // ----------------------------------------
  reg mon_d;
  reg oe_n_d;
  reg osc0_run_d;
  reg osc1_run_d;
  reg [1:0] cfg0_d;
  reg [1:0] cfg1_d;

  // decode follows the live selection code while in test mode
  always @* begin
    mon_d      = ctrl_q[`TMCM_CTRL_IDLE_LVL];
    oe_n_d     = ~ctrl_q[`TMCM_CTRL_IDLE_DRV];
    osc0_run_d = 1'b0;
    osc1_run_d = 1'b0;
    cfg0_d     = o_osc0_cfg;
    cfg1_d     = o_osc1_cfg;
    if (test_q) begin
      oe_n_d = 1'b0;
      if (!sel_s[3]) begin
        mon_d = sysck_s;
      end else begin
        case (sel_s)
          `TMCM_SEL_OSC0_STOP: begin
            oe_n_d = 1'b1;
            mon_d  = 1'b0;
          end
          `TMCM_SEL_RS0_CS0: begin
            osc0_run_d = 1'b1;
            cfg0_d     = `TMCM_CFG0_RS0_CS0;
            mon_d      = osc0_s;
          end
          `TMCM_SEL_RT0_CS0: begin
            osc0_run_d = 1'b1;
            cfg0_d     = `TMCM_CFG0_RT0_CS0;
            mon_d      = osc0_s;
          end
          `TMCM_SEL_RT01_CS0: begin
            osc0_run_d = 1'b1;
            cfg0_d     = `TMCM_CFG0_RT01_CS0;
            mon_d      = osc0_s;
          end
          `TMCM_SEL_CT01_RS0: begin
            osc0_run_d = 1'b1;
            cfg0_d     = `TMCM_CFG0_CT01_RS0;
            mon_d      = osc0_s;
          end
          `TMCM_SEL_RS1_CS1: begin
            osc1_run_d = 1'b1;
            cfg1_d     = `TMCM_CFG1_RS1_CS1;
            mon_d      = osc1_s;
          end
          `TMCM_SEL_RT1_CS1: begin
            osc1_run_d = 1'b1;
            cfg1_d     = `TMCM_CFG1_RT1_CS1;
            mon_d      = osc1_s;
          end
          default: begin
            oe_n_d = 1'b1;
            mon_d  = 1'b0;
          end
        endcase
      end
    end
  end

  // registered outputs: a source change lands on a clock edge, never mid-cycle
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_monitor_pin      <= 1'b0;
      o_monitor_pin_oe_n <= 1'b1;
      o_osc0_run         <= 1'b0;
      o_osc1_run         <= 1'b0;
      o_osc0_cfg         <= `TMCM_CFG0_RS0_CS0;
      o_osc1_cfg         <= `TMCM_CFG1_RS1_CS1;
      o_osc0_input       <= 1'b0;
      o_osc1_input       <= 1'b0;
      o_test_mode        <= 1'b0;
      o_normal_run       <= 1'b0;
    end else begin
      o_monitor_pin      <= mon_d;
      o_monitor_pin_oe_n <= oe_n_d;
      o_osc0_run         <= osc0_run_d;
      o_osc1_run         <= osc1_run_d;
      o_osc0_cfg         <= cfg0_d;
      o_osc1_cfg         <= cfg1_d;
      o_osc0_input       <= (test_q && sel_s == `TMCM_SEL_OSC0_STOP) ? mon_s : 1'b0;
      o_osc1_input       <= (test_q && sel_s == `TMCM_SEL_OSC1_STOP) ? mon_s : 1'b0;
      o_test_mode        <= test_q;
      o_normal_run       <= rstp_s & ~test_q & ~hold_q;
    end
  end

  // ----------------------------------------
  // avalon-mm register slave
  // ----------------------------------------
  reg ack_q;

  // one wait state per access; the ack drops waitrequest for exactly one edge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

  wire [31:0] status_w = {24'h000000, sel_s, 1'b0, o_normal_run, hold_q, test_q};

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q          <= 1'b0;
      ctrl_q         <= `TMCM_CTRL_RESET;
      o_avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      if (i_avs_write && !ack_q) begin
        if (i_avs_address == `TMCM_REG_CTRL) begin
          ctrl_q <= i_avs_writedata[1:0];
        end
      end
      if (i_avs_read && !ack_q) begin
        if (i_avs_address == `TMCM_REG_CTRL) begin
          o_avs_readdata <= {30'h00000000, ctrl_q};
        end else if (i_avs_address == `TMCM_REG_STATUS) begin
          o_avs_readdata <= status_w;
        end else begin
          o_avs_readdata <= 32'h00000000; // unmapped reads as zero
        end
      end
    end
  end

endmodule // tmcm_top

`default_nettype wire

// file: logic/tmcm_defs.vh
`ifndef TMCM_DEFS_VH
`define TMCM_DEFS_VH

// register word indices on the avalon slave
`define TMCM_REG_CTRL        4'h0
`define TMCM_REG_STATUS      4'h1

// control register fields
`define TMCM_CTRL_IDLE_LVL   0
`define TMCM_CTRL_IDLE_DRV   1
`define TMCM_CTRL_RESET      2'h0

// status register fields
`define TMCM_ST_TEST         0
`define TMCM_ST_HOLD         1
`define TMCM_ST_RUN          2
`define TMCM_ST_SEL_LO       4
`define TMCM_ST_SEL_HI       7

// selection codes on mode_sel
`define TMCM_SEL_OSC0_STOP   4'h8
`define TMCM_SEL_RS0_CS0     4'h9
`define TMCM_SEL_RT0_CS0     4'ha
`define TMCM_SEL_RT01_CS0    4'hb
`define TMCM_SEL_CT01_RS0    4'hc
`define TMCM_SEL_RS1_CS1     4'hd
`define TMCM_SEL_RT1_CS1     4'he
`define TMCM_SEL_OSC1_STOP   4'hf

// converter oscillator network configurations
`define TMCM_CFG0_RS0_CS0    2'h0
`define TMCM_CFG0_RT0_CS0    2'h1
`define TMCM_CFG0_RT01_CS0   2'h2
`define TMCM_CFG0_CT01_RS0   2'h3
`define TMCM_CFG1_RS1_CS1    2'h0
`define TMCM_CFG1_RT1_CS1    2'h1

// synchroniser depth
`define TMCM_SYNC_STAGES     2

`endif

// file: logic/tmcm_sync.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// two-stage level synchroniser
// ----------------------------------------
module tmcm_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_core_clk,
  input  wire             i_rst,
  // levels
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second one
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // tmcm_sync

`default_nettype wire

// file: verification/tmcm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// pin checks
// --------
module tmcm_checker (
  input wire       i_core_clk, i_rst, i_test_select_a_n, i_test_select_b_n, i_reset_pin_n,
  input wire       i_sys_rc_clk, i_adc_rc_osc0, i_adc_rc_osc1, i_monitor_pin, o_monitor_pin,
  input wire       o_monitor_pin_oe_n, o_osc0_run, o_osc1_run, o_osc0_input, o_osc1_input,
  input wire       o_test_mode, o_normal_run,
  input wire [3:0] i_mode_sel,
  input wire [1:0] o_osc0_cfg, o_osc1_cfg
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire [8:0] v = {o_test_mode, i_mode_sel, i_sys_rc_clk, i_adc_rc_osc0, i_adc_rc_osc1, i_monitor_pin};
  reg  [8:0] v_q;
  reg  [2:0] calm_q;
  reg        hold_q;
  wire       calm = calm_q == 3'h4 && v == v_q && o_test_mode;
  // routes judged only once inputs settled, as sync adds lag
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      v_q <= 9'h0;
      calm_q <= 3'h0;
      hold_q <= 1'b0;
    end else begin
      v_q <= v;
      calm_q <= (v != v_q) ? 3'h0 : (calm_q == 3'h4) ? calm_q : calm_q + 3'h1;
      hold_q <= $fell(o_test_mode) | (hold_q & ~$rose(i_reset_pin_n));
    end
  end
  sequence s_rel;
    $rose(i_reset_pin_n) && i_test_select_a_n && !i_test_select_b_n;
  endsequence
  sequence s_keep;
    (i_reset_pin_n && i_test_select_a_n && !i_test_select_b_n) [*3];
  endsequence
  a_test_entry: assert property (s_rel ##1 s_keep |-> ##[0:1] o_test_mode)
    else $error("no entry");
  a_cancel_pins: assert property ($fell(o_test_mode) |-> $past(i_test_select_a_n && i_test_select_b_n, 3))
    else $error("bad cancel");
  a_hold_run: assert property ($fell(o_test_mode) || hold_q |-> !o_normal_run)
    else $error("early run");
  a_sys_route: assert property (calm && !i_mode_sel[3] |-> !o_monitor_pin_oe_n && o_monitor_pin == i_sys_rc_clk)
    else $error("sys route");
  a_osc0_route: assert property (calm && i_mode_sel inside {[4'h9:4'hc]} |-> !o_monitor_pin_oe_n && o_osc0_run
    && o_monitor_pin == i_adc_rc_osc0 && o_osc0_cfg == i_mode_sel[1:0] - 2'h1) else $error("osc0 route");
  a_osc1_route: assert property (calm && i_mode_sel inside {4'hd, 4'he} |-> !o_monitor_pin_oe_n && o_osc1_run
    && o_monitor_pin == i_adc_rc_osc1 && o_osc1_cfg == i_mode_sel[1:0] - 2'h1) else $error("osc1 route");
  a_osc0_stop: assert property (calm && i_mode_sel == 4'h8 |-> o_monitor_pin_oe_n && !o_osc0_run
    && o_osc0_input == i_monitor_pin) else $error("osc0 stop");
  a_osc1_stop: assert property (calm && i_mode_sel == 4'hf |-> o_monitor_pin_oe_n && !o_osc1_run
    && o_osc1_input == i_monitor_pin) else $error("osc1 stop");
endmodule // tmcm_checker
bind tmcm_top tmcm_checker i_tmcm_checker (.*);
`default_nettype wire

// file: verification/tmcm_tester.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// external tester
// --------
module tmcm_tester (
  input  wire       i_core_clk,
  output reg        o_sel_a_n, o_sel_b_n, o_rst_pin_n, o_sys, o_osc0, o_osc1, o_drv,
  output reg  [3:0] o_mode_sel
);
  // idle: test pins open together, reset pin released
  initial {o_sel_a_n, o_sel_b_n, o_rst_pin_n, o_mode_sel, o_sys, o_osc0, o_osc1, o_drv} = 11'h700;
  // levels change after an edge and hold, so test pins stay put across release
  task put(input a, b, r, input [3:0] s, lv);
    @(posedge i_core_clk);
    {o_sel_a_n, o_sel_b_n, o_rst_pin_n, o_mode_sel, o_sys, o_osc0, o_osc1, o_drv} <= {a, b, r, s, lv};
  endtask
endmodule // tmcm_tester
`default_nettype wire

// file: verification/tmcm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// bench
// --------
module tmcm_top_tb;
  logic        clk = 0, rst = 1, rd = 0, wr = 0;
  logic [3:0]  ad = 4'h0;
  logic [31:0] wd = 32'h0, rq;
  wire  [31:0] rdat;
  wire  [3:0]  sel;
  wire         wq, a_n, b_n, r_n, sys, o0, o1, drv, mon, oe_n, in0, in1, tm, run;
  wire         mon_w = oe_n ? drv : mon; // pin level: tester only while device lets go
  int          err_total = 0, checks = 0;
  always #25 clk = ~clk;
  tmcm_top i_tmcm_top (.i_core_clk(clk), .i_rst(rst), .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_test_select_a_n(a_n),
    .i_test_select_b_n(b_n), .i_reset_pin_n(r_n), .i_mode_sel(sel), .i_sys_rc_clk(sys), .i_adc_rc_osc0(o0),
    .i_adc_rc_osc1(o1), .i_monitor_pin(mon_w), .o_monitor_pin(mon), .o_monitor_pin_oe_n(oe_n), .o_osc0_run(),
    .o_osc0_cfg(), .o_osc1_run(), .o_osc1_cfg(), .o_osc0_input(in0), .o_osc1_input(in1), .o_test_mode(tm),
    .o_normal_run(run));
  tmcm_tester i_tmcm_tester (.i_core_clk(clk), .o_sel_a_n(a_n), .o_sel_b_n(b_n), .o_rst_pin_n(r_n),
    .o_sys(sys), .o_osc0(o0), .o_osc1(o1), .o_drv(drv), .o_mode_sel(sel));
  task chk(input [31:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one avalon cycle; request held until a rising edge sees waitrequest low, data taken there
  task bus(input w, input [3:0] a, input [31:0] d);
    int n;
    @(posedge clk);
    rd <= !w; wr <= w; ad <= a; wd <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (wq !== 1'b0 && n < 20);
    rq = rdat;
    rd <= 0; wr <= 0;
    if (n == 20) chk(1, 0);
  endtask
  task t_regs;
    bus(1, 4'h0, 32'hffffffff);
    bus(0, 4'h0, 0); chk(rq, 32'h3);
    chk({oe_n, mon}, 2'b01);
    bus(1, 4'h1, 32'hff);
    bus(0, 4'h1, 0); chk(rq, 32'h4);
    bus(0, 4'h7, 0); chk(rq, 32'h0);
    bus(1, 4'h0, 32'h0);
    $display("regs done");
  endtask
  task t_enter;
    i_tmcm_tester.put(1, 0, 0, 4'h0, 4'h0); tick(4);
    i_tmcm_tester.put(1, 0, 1, 4'h0, 4'h0); tick(8);
    chk({tm, run}, 2'b10);
    bus(0, 4'h1, 0); chk(rq, 32'h1);
    $display("enter done");
  endtask
  // every code, both levels of each source
  task t_codes;
    logic [3:0] s, lv, e;
    logic src;
    for (int k = 0; k < 32; k++) begin
      s = k[3:0];
      lv = k[4] ? 4'ha : 4'h5;
      i_tmcm_tester.put(1, 0, 1, s, lv); tick(8);
      src = !s[3] ? lv[3] : (s < 4'hd) ? lv[2] : lv[1];
      e = (s == 4'h8) ? {2'b10, lv[0], 1'b0} : (s == 4'hf) ? {3'b100, lv[0]} : {1'b0, src, 2'b00};
      chk({oe_n, mon & ~oe_n, in0, in1}, e);
    end
    $display("codes done");
  endtask
  task t_cancel;
    i_tmcm_tester.put(0, 1, 1, 4'h0, 4'h0); tick(8);
    chk(tm, 1);
    i_tmcm_tester.put(1, 1, 1, 4'h0, 4'h0); tick(8);
    chk({tm, run}, 2'b00);
    bus(0, 4'h1, 0); chk(rq, 32'h2);
    i_tmcm_tester.put(1, 1, 0, 4'h0, 4'h0); tick(4);
    i_tmcm_tester.put(1, 1, 1, 4'h0, 4'h0); tick(8);
    chk({tm, run}, 2'b01);
    $display("cancel done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(6);
    rst <= 0;
    t_regs; t_enter; t_codes; t_cancel;
    test_done;
  end
  // about five and a half times the expected run
  initial begin
    #100000;
    err_total++;
    test_done;
  end
endmodule // tmcm_top_tb
`default_nettype wire
